// ===== rtl/opmode_pkg.sv
// opmode_pkg: constants for the operating-mode control block.
// assumes: one 100 MHz clock, registers reached over a plain strobe port.
package opmode_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [15:0] MODE_REG_ADDR  = 16'h000b;
  localparam logic [15:0] DBG_CTRL_ADDR  = 16'h00f0;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int NORMAL_BIT     = 7;
  localparam int SEL_HIGH_BIT   = 6;
  localparam int SEL_LOW_BIT    = 5;
  localparam int STRETCH_BIT    = 4;
  localparam int VIS_BIT        = 3;
  localparam int STOPWAI_BIT    = 2;
  localparam int PORT_K_EMU_BIT = 1;
  localparam int PORT_E_EMU_BIT = 0;
  // ---------------------------------------------------------------
  // mode codes {normal, high, low}
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_SPEC_SC   = 3'h0;
  localparam logic [2:0] MODE_SPEC_NAR  = 3'h1;
  localparam logic [2:0] MODE_SPEC_PER  = 3'h2;
  localparam logic [2:0] MODE_SPEC_WIDE = 3'h3;
  localparam logic [2:0] MODE_NORM_SC   = 3'h4;
  localparam logic [2:0] MODE_NORM_RSV  = 3'h6;
  // low five bits after reset
  localparam logic [4:0] LOW_RST_SPECIAL = 5'h1b;
  localparam logic [4:0] LOW_RST_NORMAL  = 5'h10;
  // ---------------------------------------------------------------
  // debug address windows
  // ---------------------------------------------------------------
  localparam logic [15:0] DBG_ROM_LO  = 16'hff20;
  localparam logic [15:0] DBG_REG_LO  = 16'hff00;
  localparam logic [15:0] DBG_REG_HI  = 16'hff06;
  localparam logic [7:0]  TOP_PAGE    = 8'hff;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int WAI_DRAIN_NS   = 40;
  localparam int WAI_DRAIN_CYC  = (WAI_DRAIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] DBG_ENABLE_BIT = 3'h0;
endpackage

// ===== rtl/operating_mode_control.sv
// operating_mode_control: mode register, bus-visibility and debug map control.
// assumes: pins synchronous to i_clk; register port strobes one cycle wide.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module operating_mode_control (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_debug_pin,
  input  wire logic        i_mode_select_high,
  input  wire logic        i_mode_select_low,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_ext_access,
  input  wire logic        i_int_access,
  input  wire logic        i_int_rw,
  input  wire logic        i_int_low_byte_strobe,
  input  wire logic [15:0] i_int_addr,
  input  wire logic [15:0] i_int_data,
  input  wire logic        i_word_access,
  input  wire logic        i_wait_mode,
  input  wire logic        i_bus_busy,
  input  wire logic        i_serial_activate,
  input  wire logic        i_debug_entry_instruction,
  input  wire logic        i_debug_exit,
  input  wire logic [15:0] i_map_addr,
  output logic [7:0]       o_rdata,
  output logic             o_bus_clock,
  output logic             o_ext_bus_en,
  output logic [7:0]       o_port_a,
  output logic [7:0]       o_port_b,
  output logic [15:0]      o_ext_addr,
  output logic             o_ext_rw,
  output logic             o_low_byte_strobe_b,
  output logic             o_vis_cycle,
  output logic             o_core_hold,
  output logic             o_bus_unit_stopped,
  output logic             o_port_k_mapped,
  output logic             o_port_e_mapped,
  output logic             o_mode_reg_mapped,
  output logic             o_debug_active,
  output logic             o_debug_enabled,
  output logic             o_sel_debug_rom,
  output logic             o_sel_debug_regs,
  output logic             o_user_top_blocked
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    WS_RUN   = 3'b001,
    WS_DRAIN = 3'b010,
    WS_STOP  = 3'b100
  } wait_state_t;

  logic        boot_r;
  logic [2:0]  mode_r;
  logic [4:0]  low_r;
  logic [6:0]  written_r;
  logic        dbg_en_r;
  logic        dbg_act_r;
  logic        half_r;
  logic [15:0] hold_data_r;
  logic [15:0] hold_addr_r;
  logic [7:0]  drain_cnt_r;
  wait_state_t ws_r;
  wait_state_t ws_nxt;

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  wire normal      = mode_r[2];
  wire peripheral  = (mode_r == opmode_pkg::MODE_SPEC_PER);
  wire single_chip = (mode_r[1:0] == 2'b00);
  wire narrow      = (mode_r[1:0] == 2'b01);
  wire expanded    = !single_chip && !peripheral;
  wire stretch_en  = low_r[opmode_pkg::STRETCH_BIT] | expanded;
  wire vis_on      = low_r[opmode_pkg::VIS_BIT] && !single_chip;
  wire stop_wai    = low_r[opmode_pkg::STOPWAI_BIT];

  wire mode_hit = (i_addr == opmode_pkg::MODE_REG_ADDR) && !peripheral;
  wire dbg_hit  = (i_addr == opmode_pkg::DBG_CTRL_ADDR);
  wire mode_wr  = i_wr && mode_hit;

  // write permission per field, index = bit position for bits 4..0; take[6] gates bit 7, take[5] bits 6:5
  wire [2:0] new_mode = {i_wdata[7], i_wdata[6], i_wdata[5]};
  wire new_legal = (new_mode != opmode_pkg::MODE_SPEC_PER) &&
                   (new_mode != opmode_pkg::MODE_NORM_RSV) &&
                   (new_mode[1:0] != 2'b10);
  wire [6:0] take;
  // first special write lands only bit 4, bit 2 never; normal writes land once, bit 2 every time, bit 7 never
  assign take[6] = !normal && written_r[6];
  assign take[5] = normal ? !written_r[5] : written_r[5];
  assign take[4] = normal ? !written_r[4] : 1'b1;
  assign take[3] = normal ? !written_r[3] : written_r[3];
  assign take[2] = normal;
  assign take[1] = normal ? !written_r[1] : written_r[1];
  assign take[0] = normal ? !written_r[0] : written_r[0];
  wire [2:0] mode_nxt = {take[6] ? i_wdata[7] : mode_r[2],
                         take[5] ? i_wdata[6:5] : mode_r[1:0]};
  wire mode_ok = !peripheral && new_legal
                 && (mode_nxt != opmode_pkg::MODE_SPEC_PER)
                 && (mode_nxt != opmode_pkg::MODE_NORM_RSV);

  wire [7:0] mode_rd = {mode_r, stretch_en, vis_on ? 1'b1 : low_r[3], low_r[2:0]};
  wire [7:0] rd_nxt  = !i_rd ? 8'h00 :
                       mode_hit ? mode_rd :
                       dbg_hit ? {6'h00, dbg_act_r, dbg_en_r} : 8'h00;

  // ---------------------------------------------------------------
  // reset capture and mode register
  // ---------------------------------------------------------------
  // pins caught on the first clock after release, never in the reset term
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      boot_r    <= 1'b1;
      mode_r    <= opmode_pkg::MODE_SPEC_SC;
      low_r     <= opmode_pkg::LOW_RST_SPECIAL;
      written_r <= 7'h00;
    end else if (boot_r) begin
      boot_r <= 1'b0;
      mode_r <= {i_debug_pin, i_mode_select_high, i_mode_select_low};
      low_r  <= i_debug_pin ? opmode_pkg::LOW_RST_NORMAL
                            : opmode_pkg::LOW_RST_SPECIAL;
    end else if (mode_wr) begin
      written_r <= 7'h7f;
      if (mode_ok) begin
        mode_r <= mode_nxt;
      end
      if (take[4]) begin
        low_r[4] <= i_wdata[4];
      end
      if (take[3]) begin
        low_r[3] <= i_wdata[3];
      end
      if (take[2]) begin
        low_r[2] <= i_wdata[2];
      end
      if (take[1]) begin
        low_r[1] <= i_wdata[1];
      end
      if (take[0]) begin
        low_r[0] <= i_wdata[0];
      end
    end
  end

  // ---------------------------------------------------------------
  // background debug
  // ---------------------------------------------------------------
  wire dbg_wr   = i_wr && dbg_hit;
  wire activate = dbg_en_r && !peripheral &&
                  (i_serial_activate || i_debug_entry_instruction);
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dbg_en_r  <= 1'b0;
      dbg_act_r <= 1'b0;
    end else if (boot_r) begin
      dbg_en_r  <= (mode_r == opmode_pkg::MODE_SPEC_SC) && !i_debug_pin
                   && !i_mode_select_high && !i_mode_select_low;
      dbg_act_r <= !i_debug_pin && !i_mode_select_high && !i_mode_select_low;
    end else begin
      if (dbg_wr) begin
        dbg_en_r <= i_wdata[opmode_pkg::DBG_ENABLE_BIT];
      end
      if (activate) begin
        dbg_act_r <= 1'b1;
      end else if (i_debug_exit) begin
        dbg_act_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // wait-mode shutdown of the bus unit
  // ---------------------------------------------------------------
  // drain delay lets a cycle already on the pins complete
  always_comb begin
    ws_nxt = ws_r;
    unique case (ws_r)
      WS_RUN:   if (i_wait_mode && stop_wai) ws_nxt = WS_DRAIN;
      WS_DRAIN: if (!i_wait_mode) ws_nxt = WS_RUN;
                else if (!i_bus_busy && drain_cnt_r == 8'h00) ws_nxt = WS_STOP;
      WS_STOP:  if (!i_wait_mode) ws_nxt = WS_RUN;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ws_r        <= WS_RUN;
      drain_cnt_r <= 8'h00;
    end else begin
      ws_r        <= ws_nxt;
      drain_cnt_r <= (ws_r == WS_RUN) ? 8'(opmode_pkg::WAI_DRAIN_CYC)
                   : (drain_cnt_r != 8'h00) ? drain_cnt_r - 8'h01 : 8'h00;
    end
  end
  wire stopped = (ws_r == WS_STOP);

  // ---------------------------------------------------------------
  // external bus
  // ---------------------------------------------------------------
  wire vis_cyc   = vis_on && i_int_access && !i_ext_access;
  wire drive_bus = !single_chip && !stopped && (i_ext_access || vis_cyc);
  // narrow word splits only on an external access; visible and hidden internal cycles never split
  wire split     = narrow && i_ext_access && i_word_access && !half_r;
  wire hidden    = i_int_access && !vis_cyc && !i_ext_access;
  // stretched clock parks high on external, low on hidden cycles
  wire clk_nxt   = !stretch_en ? !o_bus_clock :
                   i_ext_access ? 1'b1 :
                   hidden ? 1'b0 : !o_bus_clock;
  wire [15:0] addr_now = half_r ? hold_addr_r + 16'h0001 : i_int_addr;
  wire [15:0] data_now = half_r ? hold_data_r : i_int_data;
  wire [7:0]  pa_nxt = !drive_bus && !half_r ? 8'h00 :
                       narrow && !vis_cyc ? (half_r ? data_now[7:0] : data_now[15:8])
                                          : data_now[15:8];
  wire [7:0]  pb_nxt = !drive_bus ? 8'h00 :
                       narrow && !vis_cyc ? addr_now[7:0] : data_now[7:0];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      half_r      <= 1'b0;
      hold_data_r <= 16'h0000;
      hold_addr_r <= 16'h0000;
    end else begin
      half_r <= split;
      if (split) begin
        hold_data_r <= i_int_data;
        hold_addr_r <= i_int_addr;
      end
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata             <= 8'h00;
      o_bus_clock         <= 1'b0;
      o_ext_bus_en        <= 1'b0;
      o_port_a            <= 8'h00;
      o_port_b            <= 8'h00;
      o_ext_addr          <= 16'h0000;
      o_ext_rw            <= 1'b1;
      o_low_byte_strobe_b <= 1'b1;
      o_vis_cycle         <= 1'b0;
      o_core_hold         <= 1'b0;
      o_bus_unit_stopped  <= 1'b0;
      o_port_k_mapped     <= 1'b1;
      o_port_e_mapped     <= 1'b1;
      o_mode_reg_mapped   <= 1'b1;
      o_debug_active      <= 1'b0;
      o_debug_enabled     <= 1'b0;
      o_sel_debug_rom     <= 1'b0;
      o_sel_debug_regs    <= 1'b0;
      o_user_top_blocked  <= 1'b0;
    end else begin
      o_rdata             <= rd_nxt;
      o_bus_clock         <= clk_nxt;
      o_ext_bus_en        <= drive_bus || half_r;
      o_port_a            <= pa_nxt;
      o_port_b            <= pb_nxt;
      o_ext_addr          <= drive_bus || half_r ? addr_now : 16'h0000;
      o_ext_rw            <= drive_bus ? i_int_rw : 1'b1;
      o_low_byte_strobe_b <= drive_bus ? i_int_low_byte_strobe : 1'b1;
      o_vis_cycle         <= vis_cyc && drive_bus;
      o_core_hold         <= peripheral || boot_r;
      o_bus_unit_stopped  <= stopped;
      o_port_k_mapped     <= single_chip || !low_r[opmode_pkg::PORT_K_EMU_BIT];
      o_port_e_mapped     <= single_chip || peripheral
                             || !low_r[opmode_pkg::PORT_E_EMU_BIT];
      o_mode_reg_mapped   <= !peripheral;
      o_debug_active      <= dbg_act_r;
      o_debug_enabled     <= dbg_en_r;
      o_sel_debug_rom     <= dbg_act_r && (i_map_addr >= opmode_pkg::DBG_ROM_LO);
      o_sel_debug_regs    <= dbg_act_r && (i_map_addr >= opmode_pkg::DBG_REG_LO)
                             && (i_map_addr <= opmode_pkg::DBG_REG_HI);
      o_user_top_blocked  <= dbg_act_r && (i_map_addr[15:8] == opmode_pkg::TOP_PAGE);
    end
  end
endmodule
`default_nettype wire

// ===== sim/mode_props.sv
// mode_props: port-level assertions for the operating-mode control block.
// assumes: bound to operating_mode_control from the testbench file; one clock.
`timescale 1ns/100ps
`default_nettype none
module mode_props (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic [15:0] i_addr,
  input wire logic        i_rd,
  input wire logic        i_wait_mode,
  input wire logic        i_bus_busy,
  input wire logic [15:0] i_map_addr,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_ext_bus_en,
  input wire logic        o_vis_cycle,
  input wire logic        o_core_hold,
  input wire logic        o_bus_unit_stopped,
  input wire logic        o_mode_reg_mapped,
  input wire logic        o_debug_active,
  input wire logic        o_sel_debug_rom,
  input wire logic        o_sel_debug_regs,
  input wire logic        o_user_top_blocked
);
  // ---------------------------------------------------------------
  // settle counter: pins are captured and shown during the first two edges
  // ---------------------------------------------------------------
  logic [1:0] age_r;
  wire        settled;
  assign settled = (age_r == 2'h3);
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) age_r <= 2'h0;
    else if (!settled) age_r <= age_r + 2'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  hold_fixed_a: assert property (settled && $past(settled) |-> $stable(o_core_hold))
    else $error("core hold changed without reset");
  map_absent_a: assert property (settled && !o_mode_reg_mapped && i_rd
    && i_addr == 16'h000b |=> o_rdata == 8'h00)
    else $error("mode register readable while unmapped");
  stretch_one_a: assert property (settled && o_ext_bus_en && o_mode_reg_mapped && i_rd
    && i_addr == 16'h000b |=> o_rdata[4]) else $error("stretch bit low in expanded mode");
  vis_single_a: assert property (settled && !o_ext_bus_en |-> !o_vis_cycle)
    else $error("visibility cycle in single-chip mode");
  // selects lag the address by one edge, as the active flag does
  rom_select_a: assert property ((settled && i_map_addr >= 16'hff20)
    ##1 o_debug_active |-> o_sel_debug_rom) else $error("debug rom not selected");
  regs_select_a: assert property ((settled && i_map_addr >= 16'hff00
    && i_map_addr <= 16'hff06) ##1 o_debug_active |-> o_sel_debug_regs)
    else $error("debug registers not selected");
  top_block_a: assert property ((settled && i_map_addr[15:8] == 8'hff)
    ##1 o_debug_active |-> o_user_top_blocked)
    else $error("top page reachable while debugging");
  rom_idle_a: assert property (settled && !o_debug_active && !$past(o_debug_active)
    |-> !o_sel_debug_rom) else $error("debug rom selected while inactive");
  // stop shows two edges after the decision; drain needs wait held six samples
  stop_drain_a: assert property ($rose(o_bus_unit_stopped) |-> $past(i_wait_mode, 2)
    && $past(i_wait_mode, 6) && !$past(i_bus_busy, 2)) else $error("bus unit stopped early");
  cover property (o_sel_debug_rom);
  cover property ($rose(o_bus_unit_stopped));
  cover property (o_vis_cycle);
endmodule
`default_nettype wire

// ===== sim/mode_host_model.sv
// mode_host_model: strap pins and debug host on the block's far side.
// assumes: straps must hold through reset and the capture edge only.
`timescale 1ns/100ps
`default_nettype none
module mode_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic [2:0] i_strap,
  input  wire logic       i_want_debug,
  input  wire logic       i_core_hold,
  output logic            o_debug_pin,
  output logic            o_mode_select_high,
  output logic            o_mode_select_low,
  output logic            o_serial_activate
);
  logic [1:0] since_r;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) since_r <= 2'h0;
    else if (since_r != 2'h3) since_r <= since_r + 2'h1;
  end
  // straps let go after capture; inverted so a stale level cannot pass
  assign {o_debug_pin, o_mode_select_high, o_mode_select_low} =
    (since_r < 2'h2) ? i_strap : ~i_strap;
  // host stays off the debug line while the external master owns the bus
  assign o_serial_activate = i_want_debug & ~i_core_hold;
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// testbench: register and pin scenarios for operating_mode_control.
// assumes: mode_props and mode_host_model compiled before this file.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module testbench;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_ext_access = 1'b0;
  logic i_int_access = 1'b0, i_int_rw = 1'b0, i_int_low_byte_strobe = 1'b1;
  logic i_word_access = 1'b0, i_wait_mode = 1'b0, i_bus_busy = 1'b0, want_debug = 1'b0;
  logic i_debug_entry_instruction = 1'b0, i_debug_exit = 1'b0;
  logic [15:0] i_addr = 16'h0000, i_int_addr = 16'h0000, i_int_data = 16'h0000;
  logic [15:0] i_map_addr = 16'h0000;
  logic [7:0]  i_wdata = 8'h00;
  logic [2:0]  strap = 3'h0;
  wire logic dbg_pin, msel_hi, msel_lo, ser_act;
  logic [7:0] o_rdata, o_port_a, o_port_b;
  logic [15:0] o_ext_addr;
  logic o_bus_clock, o_ext_bus_en, o_ext_rw, o_low_byte_strobe_b, o_vis_cycle, o_core_hold;
  logic o_bus_unit_stopped, o_port_k_mapped, o_port_e_mapped, o_mode_reg_mapped;
  logic o_debug_active, o_debug_enabled, o_sel_debug_rom, o_sel_debug_regs;
  logic o_user_top_blocked, clk_seen;
  int n_fail = 0, cmp_count = 0, n;
  localparam logic [15:0] MR = opmode_pkg::MODE_REG_ADDR;
  localparam logic [15:0] DR = opmode_pkg::DBG_CTRL_ADDR;
  logic [2:0] modes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  always #5 i_clk = ~i_clk;
  mode_host_model host (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_strap(strap),
    .i_want_debug(want_debug), .i_core_hold(o_core_hold), .o_debug_pin(dbg_pin),
    .o_mode_select_high(msel_hi), .o_mode_select_low(msel_lo), .o_serial_activate(ser_act));
  operating_mode_control uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_debug_pin(dbg_pin),
    .i_mode_select_high(msel_hi), .i_mode_select_low(msel_lo), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ext_access(i_ext_access),
    .i_int_access(i_int_access), .i_int_rw(i_int_rw),
    .i_int_low_byte_strobe(i_int_low_byte_strobe), .i_int_addr(i_int_addr),
    .i_int_data(i_int_data), .i_word_access(i_word_access), .i_wait_mode(i_wait_mode),
    .i_bus_busy(i_bus_busy), .i_serial_activate(ser_act),
    .i_debug_entry_instruction(i_debug_entry_instruction), .i_debug_exit(i_debug_exit),
    .i_map_addr(i_map_addr), .o_rdata(o_rdata), .o_bus_clock(o_bus_clock),
    .o_ext_bus_en(o_ext_bus_en), .o_port_a(o_port_a), .o_port_b(o_port_b),
    .o_ext_addr(o_ext_addr), .o_ext_rw(o_ext_rw), .o_low_byte_strobe_b(o_low_byte_strobe_b),
    .o_vis_cycle(o_vis_cycle), .o_core_hold(o_core_hold),
    .o_bus_unit_stopped(o_bus_unit_stopped), .o_port_k_mapped(o_port_k_mapped),
    .o_port_e_mapped(o_port_e_mapped), .o_mode_reg_mapped(o_mode_reg_mapped),
    .o_debug_active(o_debug_active), .o_debug_enabled(o_debug_enabled),
    .o_sel_debug_rom(o_sel_debug_rom), .o_sel_debug_regs(o_sel_debug_regs),
    .o_user_top_blocked(o_user_top_blocked));
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  task automatic do_reset(input logic [2:0] m);
    @(posedge i_clk);
    strap <= m;
    i_rst_b <= 1'b0;
    tick(8);
    i_rst_b <= 1'b1;
    tick(4);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 `CHK("rdata", exp, o_rdata)
  endtask
  function automatic logic [7:0] exp_mode(input logic [2:0] m);
    if (m == opmode_pkg::MODE_SPEC_PER) return 8'h00;
    return {m, m[2] ? opmode_pkg::LOW_RST_NORMAL : opmode_pkg::LOW_RST_SPECIAL};
  endfunction
  task automatic stop_test;
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    foreach (modes[k]) begin
      do_reset(modes[k]);
      i_ext_access <= 1'b1;
      rd(MR, exp_mode(modes[k]));
      `CHK("core_hold", modes[k] == opmode_pkg::MODE_SPEC_PER, o_core_hold)
      `CHK("dbg_active", modes[k] == opmode_pkg::MODE_SPEC_SC, o_debug_active)
      `CHK("k_mapped", modes[k][2] | (modes[k] == 3'h0), o_port_k_mapped)
      `CHK("e_mapped", modes[k][2] | ~modes[k][0], o_port_e_mapped)
      if (modes[k] != opmode_pkg::MODE_SPEC_PER) `CHK("ext_bus", modes[k][0], o_ext_bus_en)
      i_ext_access <= 1'b0;
    end
    // peripheral: writes refused, host keeps off the debug line
    do_reset(3'h2);
    wr(MR, 8'h00);
    wr(MR, 8'h64);
    rd(MR, 8'h00);
    want_debug <= 1'b1;
    @(posedge i_clk) want_debug <= 1'b0;
    tick(2);
    #1 `CHK("core_hold", 1'b1, o_core_hold)
    `CHK("dbg_active", 1'b0, o_debug_active)
    // special narrow: first write only stretch, peripheral code refused
    do_reset(3'h1);
    wr(MR, 8'h80);
    rd(MR, 8'h3b);
    wr(MR, 8'h64);
    rd(MR, 8'h70);
    wr(MR, 8'h50);
    rd(MR, 8'h70);
    wr(MR, 8'h38);
    rd(MR, 8'h38);
    i_int_access <= 1'b1;
    i_int_low_byte_strobe <= 1'b0;
    i_int_addr <= 16'h1234;
    i_int_data <= 16'hbeef;
    tick(2);
    #1 `CHK("vis", 1'b1, o_vis_cycle)
    `CHK("ext_addr", 16'h1234, o_ext_addr)
    `CHK("ext_rw", 1'b0, o_ext_rw)
    `CHK("strobe_b", 1'b0, o_low_byte_strobe_b)
    `CHK("port_a", 8'hbe, o_port_a)
    `CHK("port_b", 8'hef, o_port_b)
    // external word in narrow mode: two byte cycles
    i_ext_access <= 1'b1;
    i_word_access <= 1'b1;
    @(posedge i_clk) #1 `CHK("port_a", 8'hbe, o_port_a)
    `CHK("bus_clock", 1'b1, o_bus_clock)
    @(posedge i_clk) #1 `CHK("port_a", 8'hef, o_port_a)
    `CHK("ext_addr", 16'h1235, o_ext_addr)
    i_ext_access <= 1'b0;
    i_word_access <= 1'b0;
    wr(MR, 8'h98);
    rd(MR, 8'h98);
    `CHK("vis", 1'b0, o_vis_cycle)
    // normal single-chip: write once, stop-in-wait any time
    do_reset(3'h4);
    wr(MR, 8'h8c);
    rd(MR, 8'h8c);
    wr(MR, 8'h90);
    rd(MR, 8'h88);
    `CHK("vis", 1'b0, o_vis_cycle)
    clk_seen = o_bus_clock;
    tick(1);
    #1 `CHK("bus_clock", ~clk_seen, o_bus_clock)
    wr(MR, 8'h84);
    i_wait_mode <= 1'b1;
    i_bus_busy <= 1'b1;
    tick(6);
    #1 `CHK("stopped", 1'b0, o_bus_unit_stopped)
    @(posedge i_clk) i_bus_busy <= 1'b0;
    n = 0;
    while (o_bus_unit_stopped !== 1'b1 && n < 4) begin
      @(posedge i_clk);
      #1 n++;
    end
    `CHK("stopped", 1'b1, o_bus_unit_stopped)
    i_wait_mode <= 1'b0;
    i_int_access <= 1'b0;
    // special wide: debug needs enable, then either activation path
    do_reset(3'h3);
    want_debug <= 1'b1;
    @(posedge i_clk) want_debug <= 1'b0;
    tick(2);
    #1 `CHK("dbg_active", 1'b0, o_debug_active)
    wr(DR, 8'h01);
    i_debug_entry_instruction <= 1'b1;
    @(posedge i_clk) i_debug_entry_instruction <= 1'b0;
    rd(DR, 8'h03);
    i_map_addr <= 16'hff20;
    tick(2);
    #1 `CHK("sel_rom", 1'b1, o_sel_debug_rom)
    `CHK("dbg_en", 1'b1, o_debug_enabled)
    i_map_addr <= 16'hff06;
    tick(2);
    #1 `CHK("sel_regs", 1'b1, o_sel_debug_regs)
    `CHK("top_blocked", 1'b1, o_user_top_blocked)
    i_debug_exit <= 1'b1;
    @(posedge i_clk) i_debug_exit <= 1'b0;
    tick(2);
    #1 `CHK("dbg_active", 1'b0, o_debug_active)
    want_debug <= 1'b1;
    @(posedge i_clk) want_debug <= 1'b0;
    tick(2);
    #1 `CHK("dbg_active", 1'b1, o_debug_active)
    stop_test();
  end
endmodule
bind operating_mode_control mode_props chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
  .i_rd(i_rd), .i_wait_mode(i_wait_mode), .i_bus_busy(i_bus_busy),
  .i_map_addr(i_map_addr), .o_rdata(o_rdata), .o_ext_bus_en(o_ext_bus_en),
  .o_vis_cycle(o_vis_cycle), .o_core_hold(o_core_hold), .o_bus_unit_stopped(o_bus_unit_stopped),
  .o_mode_reg_mapped(o_mode_reg_mapped), .o_debug_active(o_debug_active),
  .o_sel_debug_rom(o_sel_debug_rom), .o_sel_debug_regs(o_sel_debug_regs),
  .o_user_top_blocked(o_user_top_blocked));
`default_nettype wire
